/* File: core/mcs_map.vh */
// constants for the measurement cycle sequencer
//
// Overview of operation
// [R1] start routine: pressure, auto-zero, optional temperature
// [R2] repeat count selects burst of 1..128
// [R3] order: burst, t1 zero, burst, t1, burst, pzero
// [R4] second temperature steps inserted only when enabled
// [R5] final burst then common mode, then repeat
// [R6] mux picks short, diode, bridge, thermistor, signal
// [R7] six-bit coarse zero shift for sensor path
// [R8] separate six-bit zero shift for temperature
// [R9] signed codes -31..31; guaranteed -20..20
// [R10] fine offset removal stays digital, not here
// [R11] advance only on conversion done; mux held
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// ----------------------------------------
// multiplexer selection codes
// ----------------------------------------
`define MCS_MUX_W 3
`define MCS_MUX_SHORT 3'h0
`define MCS_MUX_DIODE_EXT 3'h1
`define MCS_MUX_DIODE_INT 3'h2
`define MCS_MUX_BRIDGE_RES 3'h3
`define MCS_MUX_THERMISTOR 3'h4
`define MCS_MUX_SIGNAL 3'h5
`define MCS_MUX_COMMON 3'h6

// ----------------------------------------
// temperature source codes (stored configuration)
// ----------------------------------------
`define MCS_TSRC_DIODE_EXT 2'h0
`define MCS_TSRC_DIODE_INT 2'h1
`define MCS_TSRC_BRIDGE 2'h2
`define MCS_TSRC_THERMISTOR 2'h3

// ----------------------------------------
// step kinds reported to the controller
// ----------------------------------------
`define MCS_KIND_W 3
`define MCS_KIND_PRESS 3'h0
`define MCS_KIND_PZERO 3'h1
`define MCS_KIND_T1ZERO 3'h2
`define MCS_KIND_T1 3'h3
`define MCS_KIND_T2ZERO 3'h4
`define MCS_KIND_T2 3'h5
`define MCS_KIND_COMMON 3'h6

// ----------------------------------------
// zero shift code limits
// ----------------------------------------
`define MCS_ZS_W 6
`define MCS_ZS_MAX 6'h1f
`define MCS_ZS_MIN 6'h21
`define MCS_ZS_GUAR_MAX 6'h14
`define MCS_ZS_GUAR_MIN 6'h2c
`define MCS_ZS_ZERO 6'h00

`endif

/* File: core/mcs_sequencer.v */
// measurement cycle sequencer for the analog front end
`include "mcs_map.vh"

module mcs_sequencer #(
	parameter CNT_W = 8 // burst counter width, 128 max
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// stored configuration
	input wire cfg_load,
	input wire [2:0] pressure_repeat_count,
	input wire second_temp_enable,
	input wire [1:0] t1_source,
	input wire [1:0] t2_source,
	input wire [`MCS_ZS_W-1:0] coarse_zero_shift_in,
	input wire [`MCS_ZS_W-1:0] temp_zero_shift_in,
	// converter handshake
	input wire conv_done,
	output reg conv_start,
	output reg [`MCS_MUX_W-1:0] mux_sel,
	output reg short_input,
	output reg [`MCS_KIND_W-1:0] step_kind,
	output reg in_start_routine,
	// zero shift codes to the analog path
	output wire [`MCS_ZS_W-1:0] coarse_zero_shift,
	output wire [`MCS_ZS_W-1:0] zero_shift_code,
	output wire zs_range_err,
	output wire zs_unguaranteed,
	output reg cycle_wrap
);
	// ----------------------------------------
	// states, one-hot
	// ----------------------------------------
	localparam S_IDLE = 3'h1;
	localparam S_ISSUE = 3'h2;
	localparam S_WAIT = 3'h4;

	// step slots of the normal cycle
	localparam SL_P0 = 4'h0;
	localparam SL_T1Z = 4'h1;
	localparam SL_P1 = 4'h2;
	localparam SL_T1 = 4'h3;
	localparam SL_P2 = 4'h4;
	localparam SL_PZ = 4'h5;
	localparam SL_P3 = 4'h6;
	localparam SL_T2Z = 4'h7;
	localparam SL_P4 = 4'h8;
	localparam SL_T2 = 4'h9;
	localparam SL_P5 = 4'ha;
	localparam SL_CM = 4'hb;
	// start routine slots
	localparam SL_SP = 4'hc;
	localparam SL_SPZ = 4'hd;
	localparam SL_ST1Z = 4'he;
	localparam SL_ST1 = 4'hf;

	reg [2:0] state;
	reg [3:0] slot; // current step
	reg [CNT_W-1:0] burst_left; // conversions remaining in the current step
	reg [2:0] rep_code; // latched repeat code
	reg t2_en; // latched second temperature enable
	reg [1:0] t1src;
	reg [1:0] t2src;
	reg [3:0] next_slot;
	reg [`MCS_MUX_W-1:0] next_mux;
	reg [`MCS_KIND_W-1:0] next_kind;
	reg [`MCS_MUX_W-1:0] t1_mux;
	reg [`MCS_MUX_W-1:0] t2_mux;
	reg zs_err_a;
	reg zs_err_b;
	reg zs_ug_a;
	reg zs_ug_b;
	reg zs_err_q; // combined range error, registered
	reg zs_ug_q; // combined unguaranteed flag, registered

	wire [CNT_W-1:0] burst_len = {{(CNT_W-1){1'b0}}, 1'b1} << rep_code; // R2
	wire is_press = (slot == SL_P0) || (slot == SL_P1) || (slot == SL_P2) ||
		(slot == SL_P3) || (slot == SL_P4) || (slot == SL_P5) || (slot == SL_SP);

	// ----------------------------------------
	// zero shift holders
	// ----------------------------------------
	mcs_zero_shift u_bridge_zs (
		.clk(clk),
		.rst_n(rst_n),
		.load(cfg_load),
		.code_in(coarse_zero_shift_in),
		.code(coarse_zero_shift), // R7
		.out_of_range(zs_err_a),
		.unguaranteed(zs_ug_a)
	);
	mcs_zero_shift u_temp_zs (
		.clk(clk),
		.rst_n(rst_n),
		.load(cfg_load),
		.code_in(temp_zero_shift_in),
		.code(zero_shift_code), // R8
		.out_of_range(zs_err_b),
		.unguaranteed(zs_ug_b)
	);
	// ----------------------------------------
	// combined zero shift flags
	// ----------------------------------------
	// registered so the ports come straight from flops;
	// costs one cycle behind the holders' own flags
	always @(posedge clk) begin
		if (!rst_n) begin
			zs_err_q <= 1'b0;
			zs_ug_q <= 1'b0;
		end else begin
			zs_err_q <= zs_err_a | zs_err_b; // R9
			zs_ug_q <= zs_ug_a | zs_ug_b; // R9
		end
	end
	assign zs_range_err = zs_err_q;
	assign zs_unguaranteed = zs_ug_q;

	// ----------------------------------------
	// temperature source to mux code
	// ----------------------------------------
	function [`MCS_MUX_W-1:0] src_mux;
		input [1:0] src;
		begin
			case (src)
				`MCS_TSRC_DIODE_EXT: src_mux = `MCS_MUX_DIODE_EXT;
				`MCS_TSRC_DIODE_INT: src_mux = `MCS_MUX_DIODE_INT;
				`MCS_TSRC_BRIDGE: src_mux = `MCS_MUX_BRIDGE_RES;
				default: src_mux = `MCS_MUX_THERMISTOR;
			endcase
		end
	endfunction

	// ----------------------------------------
	// slot successor; skips second temperature when disabled
	// ----------------------------------------
	always @* begin
		t1_mux = src_mux(t1src); // R6
		t2_mux = src_mux(t2src);
		case (slot)
			SL_SP: next_slot = SL_SPZ; // R1
			SL_SPZ: next_slot = t2_en ? SL_ST1Z : SL_P0; // R1
			SL_ST1Z: next_slot = SL_ST1;
			SL_ST1: next_slot = SL_P0;
			SL_PZ: next_slot = t2_en ? SL_P3 : SL_P5; // R4
			SL_CM: next_slot = SL_P0; // R5
			default: next_slot = slot + 4'h1; // R3
		endcase
		// mux and kind for the current slot
		case (slot)
			SL_T1Z, SL_T2Z, SL_PZ, SL_SPZ, SL_ST1Z: next_mux = `MCS_MUX_SHORT; // R6
			SL_T1, SL_ST1: next_mux = t1_mux;
			SL_T2: next_mux = t2_mux;
			SL_CM: next_mux = `MCS_MUX_COMMON;
			default: next_mux = `MCS_MUX_SIGNAL; // R10
		endcase
		case (slot)
			SL_T1Z, SL_ST1Z: next_kind = `MCS_KIND_T1ZERO;
			SL_T1, SL_ST1: next_kind = `MCS_KIND_T1;
			SL_PZ, SL_SPZ: next_kind = `MCS_KIND_PZERO;
			SL_T2Z: next_kind = `MCS_KIND_T2ZERO;
			SL_T2: next_kind = `MCS_KIND_T2;
			SL_CM: next_kind = `MCS_KIND_COMMON;
			default: next_kind = `MCS_KIND_PRESS;
		endcase
	end

	// ----------------------------------------
	// main stepper: issue, wait done, advance
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			slot <= SL_SP;
			burst_left <= {CNT_W{1'b0}};
			rep_code <= 3'h0;
			t2_en <= 1'b0;
			t1src <= 2'h0;
			t2src <= 2'h0;
			conv_start <= 1'b0;
			mux_sel <= `MCS_MUX_SHORT;
			// the mux parks on the short, so the short flag must agree
			short_input <= 1'b1;
			step_kind <= `MCS_KIND_PRESS;
			in_start_routine <= 1'b1;
			cycle_wrap <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			cycle_wrap <= 1'b0;
			case (state)
				// settings are taken once, before the first step
				S_IDLE: begin
					if (cfg_load) begin
						rep_code <= pressure_repeat_count;
						t2_en <= second_temp_enable;
						t1src <= t1_source;
						t2src <= t2_source;
						state <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					mux_sel <= next_mux; // R11
					short_input <= (next_mux == `MCS_MUX_SHORT);
					step_kind <= next_kind;
					conv_start <= 1'b1;
					// start routine pressure is a single conversion
					if (burst_left == {CNT_W{1'b0}})
						burst_left <= (is_press && slot != SL_SP) ? burst_len : {{(CNT_W-1){1'b0}}, 1'b1};
					state <= S_WAIT;
				end
				S_WAIT: begin
					if (conv_done) begin // R11
						burst_left <= burst_left - {{(CNT_W-1){1'b0}}, 1'b1};
						if (burst_left == {{(CNT_W-1){1'b0}}, 1'b1}) begin
							slot <= next_slot; // R3
							if (slot == SL_CM)
								cycle_wrap <= 1'b1; // R5
							if (next_slot == SL_P0)
								in_start_routine <= 1'b0;
						end
						state <= S_ISSUE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: core/mcs_zero_shift.v */
// zero shift code holder with range checks
`include "mcs_map.vh"

module mcs_zero_shift (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// nonvolatile load
	input wire load,
	input wire [`MCS_ZS_W-1:0] code_in,
	// held code and flags
	output reg [`MCS_ZS_W-1:0] code,
	output reg out_of_range,
	output reg unguaranteed
);
	// ----------------------------------------
	// signed views of the incoming code
	// ----------------------------------------
	wire signed [`MCS_ZS_W-1:0] s_in = code_in;
	wire signed [`MCS_ZS_W-1:0] s_max = `MCS_ZS_MAX;
	wire signed [`MCS_ZS_W-1:0] s_min = `MCS_ZS_MIN;
	wire signed [`MCS_ZS_W-1:0] g_max = `MCS_ZS_GUAR_MAX;
	wire signed [`MCS_ZS_W-1:0] g_min = `MCS_ZS_GUAR_MIN;
	wire bad = (s_in > s_max) || (s_in < s_min); // only -32 fails
	wire loose = (s_in > g_max) || (s_in < g_min);

	// ----------------------------------------
	// capture; -32 is refused and clamps to zero
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			code <= `MCS_ZS_ZERO;
			out_of_range <= 1'b0;
			unguaranteed <= 1'b0;
		end else if (load) begin
			code <= bad ? `MCS_ZS_ZERO : code_in; // R9
			out_of_range <= bad; // R9
			unguaranteed <= loose & ~bad; // R9
		end
	end
endmodule

/* File: sim/mcs_front_model.sv */
// behavioural converter front end answering each conversion start
module mcs_front_model (
	// clock and handshake
	input wire logic clk,
	input wire logic conv_start,
	output logic conv_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int d; // conversion length, varied so prompt and slow answers mix
	initial conv_done = 1'b0;
	// one done pulse per start; a busy converter cannot take a new start
	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			d = $urandom_range(3, 1);
			repeat (d) @(posedge clk);
			@(negedge clk) conv_done = 1'b1;
			@(negedge clk) conv_done = 1'b0;
		end
	end
endmodule

/* File: sim/mcs_sequencer_properties.sv */
// assertions on the sequencer ports
`include "mcs_map.vh"
module mcs_sequencer_properties #(
	parameter CNT_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration and handshake
	input wire logic cfg_load,
	input wire logic [5:0] coarse_zero_shift_in,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic [2:0] mux_sel,
	input wire logic short_input,
	input wire logic [2:0] step_kind,
	input wire logic cycle_wrap,
	input wire logic [5:0] coarse_zero_shift,
	input wire logic zs_range_err
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic busy; // conversion in flight
	// tracker: set by start, cleared by done
	always @(posedge clk) begin
		if (!rst_n || conv_done)
			busy <= 1'b0;
		else if (conv_start)
			busy <= 1'b1;
	end
	chk_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
	chk_no_restart: assert property (busy && !conv_done |=> !conv_start) else $error("start before done");
	chk_mux_hold: assert property (busy && !conv_done |=> $stable(mux_sel) && $stable(step_kind))
		else $error("selection moved");
	chk_press_mux: assert property (conv_start && step_kind == `MCS_KIND_PRESS |-> mux_sel == `MCS_MUX_SIGNAL)
		else $error("pressure mux");
	chk_common_mux: assert property (conv_start && step_kind == `MCS_KIND_COMMON |-> mux_sel == `MCS_MUX_COMMON)
		else $error("common mux");
	chk_short_flag: assert property (short_input == (mux_sel == `MCS_MUX_SHORT)) else $error("short flag");
	chk_wrap_cause: assert property (cycle_wrap |-> $past(step_kind) == `MCS_KIND_COMMON) else $error("wrap");
	// the combined error flag is registered once more behind the holder
	chk_zs_clamp: assert property (cfg_load && coarse_zero_shift_in == 6'h20 |=>
		coarse_zero_shift == 6'h00 ##1 zs_range_err) else $error("clamp");
	cover property (conv_start && step_kind == `MCS_KIND_T2);
	cover property (cycle_wrap);
	cover property (zs_range_err);
endmodule
bind mcs_sequencer mcs_sequencer_properties #(.CNT_W(CNT_W)) i_mcs_sequencer_properties (.clk(clk), .rst_n(rst_n),
	.cfg_load(cfg_load), .coarse_zero_shift_in(coarse_zero_shift_in), .conv_done(conv_done), .conv_start(conv_start),
	.mux_sel(mux_sel), .short_input(short_input), .step_kind(step_kind), .cycle_wrap(cycle_wrap),
	.coarse_zero_shift(coarse_zero_shift), .zs_range_err(zs_range_err));

/* File: sim/tb_mcs_sequencer.sv */
// self-checking bench for the measurement cycle sequencer
`include "mcs_map.vh"
module tb_mcs_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_load = 1'b0;
	logic [2:0] rep = 3'h0; // burst length code
	logic t2_on = 1'b0;
	logic [1:0] t1s = 2'h0;
	logic [1:0] t2s = 2'h0;
	logic [5:0] zs = 6'h00;
	logic conv_done, conv_start, short_input, in_start_routine, cycle_wrap, zs_range_err, zs_unguaranteed;
	logic [2:0] mux_sel, step_kind;
	logic [5:0] coarse_zero_shift, zero_shift_code, e;
	logic [5:0] q[$]; // expected {kind, mux}
	logic [5:0] zv[7] = '{6'h00, 6'h20, 6'h15, 6'h2c, 6'h2b, 6'h1f, 6'h14};
	int n_mismatch = 0;
	int check_count = 0;
	int n;
	int n_wrap = 0; // wrap pulses seen in this run
	always #5 clk = ~clk;
	mcs_sequencer i_mcs_sequencer (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load), .pressure_repeat_count(rep),
		.second_temp_enable(t2_on), .t1_source(t1s), .t2_source(t2s), .coarse_zero_shift_in(zs),
		.temp_zero_shift_in(zs), .conv_done(conv_done), .conv_start(conv_start), .mux_sel(mux_sel),
		.short_input(short_input), .step_kind(step_kind), .in_start_routine(in_start_routine),
		.coarse_zero_shift(coarse_zero_shift), .zero_shift_code(zero_shift_code),
		.zs_range_err(zs_range_err), .zs_unguaranteed(zs_unguaranteed), .cycle_wrap(cycle_wrap));
	mcs_front_model i_mcs_front_model (.clk(clk), .conv_start(conv_start), .conv_done(conv_done));
	task chk(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task push(input logic [2:0] k, input logic [2:0] m, input int reps);
		repeat (reps) q.push_back({k, m});
	endtask
	// expected holder outputs: -32 clamps to zero, beyond 20 is unguaranteed
	function logic [13:0] zexp(input logic [5:0] c);
		logic err;
		err = (c == 6'h20);
		return {err ? 12'h000 : {c, c}, err, !err && ($signed(c) > 6'sd20 || $signed(c) < -6'sd20)};
	endfunction
	// monitor: every start takes the oldest expectation; wraps are counted
	always @(posedge clk) begin
		if (cycle_wrap === 1'b1)
			n_wrap++;
		if (conv_start === 1'b1) begin
			e = (q.size() > 0) ? q.pop_front() : 6'h3f;
			chk({8'h00, step_kind, mux_sel}, {8'h00, e});
		end
	end
	initial begin
		void'($urandom(32'h0e27c445));
		for (int r = 0; r < 4; r++) begin
			rst_n = 1'b0;
			cfg_load = 1'b0;
			repeat (6) @(negedge clk);
			rep = (r == 1) ? 3'h7 : 3'($urandom_range(3));
			t2_on = r[0];
			t1s = 2'(r); // each temperature source once over the runs
			t2s = 2'($urandom);
			q = {};
			n_wrap = 0;
			push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1);
			push(`MCS_KIND_PZERO, `MCS_MUX_SHORT, 1);
			if (t2_on) begin
				push(`MCS_KIND_T1ZERO, `MCS_MUX_SHORT, 1);
				push(`MCS_KIND_T1, {1'b0, t1s} + 3'h1, 1);
			end
			// two full loops so the wrap back to the first burst is seen
			repeat (2) begin
				push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
				push(`MCS_KIND_T1ZERO, `MCS_MUX_SHORT, 1);
				push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
				push(`MCS_KIND_T1, {1'b0, t1s} + 3'h1, 1);
				push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
				push(`MCS_KIND_PZERO, `MCS_MUX_SHORT, 1);
				if (t2_on) begin
					push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
					push(`MCS_KIND_T2ZERO, `MCS_MUX_SHORT, 1);
					push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
					push(`MCS_KIND_T2, {1'b0, t2s} + 3'h1, 1);
				end
				push(`MCS_KIND_PRESS, `MCS_MUX_SIGNAL, 1 << rep);
				push(`MCS_KIND_COMMON, `MCS_MUX_COMMON, 1);
			end
			rst_n = 1'b1;
			cfg_load = 1'b1;
			// holders reload while the sequencer already runs
			for (int i = 0; i < 7; i++) begin
				zs = (i == 0) ? 6'($urandom) : zv[i];
				repeat (2) @(negedge clk);
				chk({zero_shift_code, coarse_zero_shift, zs_range_err, zs_unguaranteed}, zexp(zs));
			end
			cfg_load = 1'b0;
			n = 0;
			while (q.size() > 0 && n < 20000) begin
				@(negedge clk);
				n++;
			end
			chk({13'h0000, in_start_routine}, 14'h0000);
			// first loop has wrapped; the second common step is still converting
			chk(14'(n_wrap), 14'h0001);
			if (n >= 20000) begin
				n_mismatch++;
				r = 4;
			end
		end
		conclude();
	end
endmodule
